// File: verilog/fdpc_pkg.sv
// constants, field layouts and carrier types for the fan drive pin control
// assumes a single 10 MHz reference clock and an APB register port
package fdpc_pkg;
  localparam int NCH = 6;
  localparam int NTACH = 12;
  localparam int CW = 11;
  localparam int AW = 8;
  localparam int PWM_DIV_DEF = 2;
  // ----------------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] A_GCFG = 8'h00;
  localparam logic [7:0] A_CHCFG = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_IMASK = 8'h0C;
  localparam logic [7:0] A_CHT0 = 8'h10;
  localparam logic [7:0] A_TCNT0 = 8'h28;
  localparam logic [7:0] A_PSTAT = 8'h58;
  localparam logic [7:0] A_STEP = 8'h04;
  localparam logic [31:0] GCFG_RST = 32'h00000000;
  localparam logic [31:0] CHCFG_RST = 32'h00000000;
  localparam logic [31:0] CHT_RST = 32'h00000000;
  localparam logic [5:0] IMASK_RST = 6'h00;
  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int F_XTAL = 0;
  localparam int F_STBY = 1;
  localparam int F_FLIM = 2;
  localparam int F_RATE = 4;
  localparam int F_NPER = 7;
  localparam int F_FOF = 9;
  localparam int F_PIN = 0;
  localparam int F_ZOF = 6;
  localparam int F_FMSK = 12;
  localparam int F_ANA = 18;
  localparam int F_LR = 24;
  localparam int F_TTGT = 16;
  localparam int F_RPM = 31;
  // ----------------------------------------------------------------------
  // duty, tach and timing figures
  // ----------------------------------------------------------------------
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  localparam logic [7:0] PWM_TOP = 8'hFE;
  localparam logic [3:0][7:0] INIT_DUTY = {8'hFF, 8'hBF, 8'h66, 8'h00};
  localparam logic [3:0][2:0] FAIL_LIM = {3'h6, 3'h4, 3'h2, 3'h1};
  localparam logic [3:0][3:0] NPER = {4'h8, 4'h4, 4'h2, 4'h1};
  localparam logic [CW-1:0] CNT_MAX = 11'h7FF;
  localparam longint OSC_HZ = 32768;
  localparam longint REF_HZ = 10000000;
  localparam int NCO_W = 24;
  localparam logic [NCO_W-1:0] NCO_INC =
    NCO_W'((2 * OSC_HZ * (longint'(1) << NCO_W)) / REF_HZ);
  localparam logic [1:0] TICK_DIV_M1 = 2'h3;
  localparam int RCNT_W = 11;
  localparam logic [RCNT_W-1:0] RATE_BASE = 11'h008;
  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic analog;
    logic lr;
    logic [1:0] nper;
  } fdpc_tcfg_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AW-1:0] paddr;
    logic [31:0] pwdata;
  } fdpc_apb_req_t;
  typedef enum logic [1:0] {
    S_INIT = 2'b01,
    S_RUN = 2'b10
  } fdpc_st_t;
endpackage

// File: verilog/fdpc_tach.sv
// speed-pulse period counter for one tach source
// assumes i_pulse synchronous to i_clk and i_tick one cycle at 8192 Hz
`timescale 1ns/1ps
module fdpc_tach
  import fdpc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_tick,
  input wire logic i_pulse,
  input wire fdpc_tcfg_t i_cfg,
  output logic [CW-1:0] o_count,
  output logic o_done,
  output logic o_fail
);
  typedef struct packed {
    logic prev;
    logic [CW-1:0] cnt;
    logic [3:0] per;
    logic [CW-1:0] count;
    logic done;
    logic fail;
  } fdpc_tach_t;
  fdpc_tach_t q;
  fdpc_tach_t n;
  logic rise;

  always_comb
  begin
    n = q;
    n.done = 1'b0;
    n.fail = 1'b0;
    n.prev = i_pulse;
    rise = i_pulse & ~q.prev;
    if (!i_cfg.en)
    begin
      n.cnt = '0;
      n.per = '0;
    end
    else
    begin
      if (i_tick)
        n.cnt = q.cnt + 11'h001;
      // no edges for a full count window: stalled or missing fan
      if (i_tick && q.cnt == CNT_MAX)
      begin
        n.cnt = '0;
        n.per = '0;
        n.fail = 1'b1;
      end
      if (i_tick && i_cfg.lr && i_pulse)
        n.fail = 1'b1;
      if (rise)
      begin
        n.per = q.per + 4'h1;
        if (q.per + 4'h1 == NPER[i_cfg.nper])
        begin
          n.per = '0;
          n.cnt = '0;
          n.done = 1'b1;
          if (!i_cfg.analog)
            n.count = q.cnt;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q <= '0;
      // pulse lines idle high on their pull-ups: no false edge at release
      q.prev <= 1'b1;
    end
    else if (i_ce)
      q <= n;
  end

  assign o_count = q.count;
  assign o_done = q.done;
  assign o_fail = q.fail;
endmodule

// File: verilog/fdpc_clkgen.sv
// 32768 Hz clock source: internal NCO or sampled crystal, plus 8192 Hz tick
// assumes the crystal pin level is synchronous to i_clk
`timescale 1ns/1ps
module fdpc_clkgen
  import fdpc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_xtal_en,
  input wire logic i_xtal,
  output logic o_clk,
  output logic o_xout,
  output logic o_tick
);
  typedef struct packed {
    logic [NCO_W-1:0] acc;
    logic iclk;
    logic xs;
    logic xout;
    logic out;
    logic [1:0] div;
    logic tick;
  } fdpc_clk_t;
  fdpc_clk_t q;
  fdpc_clk_t n;
  logic carry;
  logic [NCO_W-1:0] sum;
  logic src;

  always_comb
  begin
    n = q;
    {carry, sum} = {1'b0, q.acc} + {1'b0, NCO_INC};
    n.acc = sum;
    if (carry)
      n.iclk = ~q.iclk;
    n.xs = i_xtal;
    n.xout = ~i_xtal;
    // nothing can gate the output; only the source changes
    src = i_xtal_en ? q.xs : q.iclk;
    n.out = src;
    n.tick = 1'b0;
    if (src && !q.out)
    begin
      n.div = q.div + 2'h1;
      if (q.div == TICK_DIV_M1)
        n.tick = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q <= '0;
    else if (i_ce)
      q <= n;
  end

  assign o_clk = q.out;
  assign o_xout = q.xout;
  assign o_tick = q.tick;
endmodule

// File: verilog/fdpc_top.sv
// six-channel fan drive pin control with APB registers
// assumes all pin inputs synchronous to I_REF_CLK, open-drain pins resolved
// outside from the _OE_N enables (low = pull low)
`timescale 1ns/1ps
module fdpc_top
  import fdpc_pkg::*;
#(
  parameter int PWM_DIV = PWM_DIV_DEF
)
(
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic I_CE,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [AW-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [NCH-1:0] I_SPEED_PULSE_INPUT,
  input wire logic [NCH-1:0] I_FAN_DRIVE_OUTPUT_I,
  output logic [NCH-1:0] O_FAN_DRIVE_OUTPUT_O,
  output logic [NCH-1:0] O_FAN_DRIVE_OUTPUT_OE_N,
  input wire logic I_FULL_SPEED_N,
  output logic O_FAN_FAIL_O,
  output logic O_FAN_FAIL_OE_N,
  input wire logic I_INITIAL_DUTY_SELECT_LO,
  input wire logic I_INITIAL_DUTY_SELECT_HI,
  input wire logic I_CRYSTAL_PIN_IN,
  output logic O_CRYSTAL_PIN_OUT,
  output logic O_OSC_CLOCK_OUTPUT,
  output logic O_IRQ
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    fdpc_st_t st;
    logic [31:0] gcfg;
    logic [31:0] chcfg;
    logic [NCH-1:0] imask;
    logic [NCH-1:0] stat;
    logic [NCH-1:0][31:0] cht;
    logic [NCH-1:0][7:0] duty;
    logic [NCH-1:0][7:0] rpmd;
    logic [NCH-1:0][2:0] fcnt;
    logic [NCH-1:0] fault;
    logic [7:0] pdiv;
    logic [7:0] pwmc;
    logic [RCNT_W-1:0] rcnt;
    logic [NCH-1:0] drv_oe_n;
    logic fail_oe_n;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } fdpc_top_t;

  fdpc_top_t q;
  fdpc_top_t n;
  logic [1:0] rsync_r;
  logic rst_n;
  fdpc_apb_req_t req;
  logic [NTACH-1:0][CW-1:0] tcount;
  logic [NTACH-1:0] tdone;
  logic [NTACH-1:0] tfail;
  fdpc_tcfg_t [NTACH-1:0] tcfg;
  logic tick;
  logic osc_clk;
  logic xout;

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      rsync_r <= 2'b00;
    else
      rsync_r <= {rsync_r[0], 1'b1};
  end
  assign rst_n = rsync_r[1];

  assign req = '{psel: I_PSEL, penable: I_PENABLE, pwrite: I_PWRITE,
                 paddr: I_PADDR, pwdata: I_PWDATA};

  // ----------------------------------------------------------------------
  // clock source and tach counters
  // ----------------------------------------------------------------------
  fdpc_clkgen u_clk (
    .i_clk(I_REF_CLK),
    .i_rst_n(rst_n),
    .i_ce(I_CE),
    .i_xtal_en(q.gcfg[F_XTAL]),
    .i_xtal(I_CRYSTAL_PIN_IN),
    .o_clk(osc_clk),
    .o_xout(xout),
    .o_tick(tick)
  );

  // sources 0..5 are dedicated inputs, 6..11 the fan pins in input mode
  for (genvar g = 0; g < NTACH; g++)
  begin : g_tach
    localparam int C = g % NCH;
    if (g < NCH)
    begin : g_ded
      assign tcfg[g] = '{en: 1'b1, analog: q.chcfg[F_ANA + C],
                         lr: q.chcfg[F_LR + C],
                         nper: q.gcfg[F_NPER +: 2]};
    end
    else
    begin : g_pin
      assign tcfg[g] = '{en: q.chcfg[F_PIN + C], analog: 1'b0, lr: 1'b0,
                         nper: q.gcfg[F_NPER +: 2]};
    end
    fdpc_tach u_tach (
      .i_clk(I_REF_CLK),
      .i_rst_n(rst_n),
      .i_ce(I_CE),
      .i_tick(tick),
      .i_pulse(g < NCH ? I_SPEED_PULSE_INPUT[C] : I_FAN_DRIVE_OUTPUT_I[C]),
      .i_cfg(tcfg[g]),
      .o_count(tcount[g]),
      .o_done(tdone[g]),
      .o_fail(tfail[g])
    );
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic access;
    logic commit;
    logic hit;
    logic [31:0] rd;
    logic [NCH-1:0] fnow;
    logic [NCH-1:0] pres;
    logic full;
    logic step;
    logic [7:0] base;
    logic [7:0] tgt;
    logic [CW-1:0] ttgt;
    logic [RCNT_W-1:0] rlim;
    access = 1'b0;
    commit = 1'b0;
    hit = 1'b0;
    rd = '0;
    fnow = '0;
    pres = '0;
    full = 1'b0;
    step = 1'b0;
    base = '0;
    tgt = '0;
    ttgt = '0;
    rlim = '0;
    n = q;

    // register read mux and decode
    case (req.paddr)
      A_GCFG:
      begin
        hit = 1'b1;
        rd = q.gcfg;
      end
      A_CHCFG:
      begin
        hit = 1'b1;
        rd = q.chcfg;
      end
      A_STAT:
      begin
        hit = 1'b1;
        rd = {26'h0000000, q.stat};
      end
      A_IMASK:
      begin
        hit = 1'b1;
        rd = {26'h0000000, q.imask};
      end
      A_PSTAT:
      begin
        hit = 1'b1;
        rd = {25'h0000000, ~I_FULL_SPEED_N, q.fault};
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    for (int i = 0; i < NCH; i++)
    begin
      if (req.paddr == A_CHT0 + AW'(i * A_STEP))
      begin
        hit = 1'b1;
        rd = q.cht[i];
      end
    end
    for (int i = 0; i < NTACH; i++)
    begin
      if (req.paddr == A_TCNT0 + AW'(i * A_STEP))
      begin
        hit = 1'b1;
        rd = {21'h000000, tcount[i]};
      end
    end

    // apb: one wait state, then pready with data
    access = req.psel & req.penable;
    commit = access & q.pready;
    n.pready = access & ~q.pready;
    n.pslverr = access & ~q.pready & ~hit;
    if (access && !q.pready)
      n.prdata = rd;
    if (commit && req.pwrite)
    begin
      case (req.paddr)
        A_GCFG: n.gcfg = req.pwdata;
        A_CHCFG: n.chcfg = req.pwdata;
        A_IMASK: n.imask = req.pwdata[NCH-1:0];
        default: n.gcfg = q.gcfg;
      endcase
      for (int i = 0; i < NCH; i++)
      begin
        if (req.paddr == A_CHT0 + AW'(i * A_STEP))
          n.cht[i] = req.pwdata;
      end
    end
    if (commit && !req.pwrite && req.paddr == A_STAT)
      n.stat = '0;

    // fault counting per channel
    for (int i = 0; i < NCH; i++)
    begin
      if (tfail[i] || (tfail[i + NCH] && q.chcfg[F_PIN + i]))
      begin
        if (q.fcnt[i] != FAIL_LIM[q.gcfg[F_FLIM +: 2]])
          n.fcnt[i] = q.fcnt[i] + 3'h1;
      end
      else if (tdone[i])
        n.fcnt[i] = '0;
      fnow[i] = (n.fcnt[i] == FAIL_LIM[q.gcfg[F_FLIM +: 2]]);
      pres[i] = fnow[i] & ~q.chcfg[F_FMSK + i];
    end
    n.fault = pres;
    n.stat = n.stat | (pres & ~q.fault);
    n.irq = |(n.stat & q.imask);
    n.fail_oe_n = ~|pres;

    // ramp pacing in 8192 Hz ticks; rate 0 means no pacing
    rlim = RATE_BASE << q.gcfg[F_RATE +: 3];
    if (q.gcfg[F_RATE +: 3] == 3'h0)
      step = 1'b1;
    else if (tick)
    begin
      n.rcnt = q.rcnt + 11'h001;
      if (n.rcnt >= rlim)
      begin
        step = 1'b1;
        n.rcnt = '0;
      end
    end

    full = ~I_FULL_SPEED_N | (q.gcfg[F_FOF] & |pres);
    for (int i = 0; i < NCH; i++)
    begin
      // closed loop: long period count means the fan is too slow
      ttgt = q.cht[i][F_TTGT +: CW];
      if (tdone[i] && !q.chcfg[F_ANA + i] && q.cht[i][F_RPM])
      begin
        if (tcount[i] > ttgt && q.rpmd[i] != DUTY_FULL)
          n.rpmd[i] = q.rpmd[i] + 8'h01;
        else if (tcount[i] < ttgt && q.rpmd[i] != DUTY_ZERO)
          n.rpmd[i] = q.rpmd[i] - 8'h01;
      end
      base = q.cht[i][F_RPM] ? q.rpmd[i] : q.cht[i][7:0];
      if (q.gcfg[F_STBY])
        base = DUTY_ZERO;
      if (fnow[i] && q.chcfg[F_ZOF + i])
        tgt = DUTY_ZERO;
      else if (full)
        tgt = DUTY_FULL;
      else
        tgt = base;
      if (step && q.duty[i] < tgt)
        n.duty[i] = q.duty[i] + 8'h01;
      else if (step && q.duty[i] > tgt)
        n.duty[i] = q.duty[i] - 8'h01;
    end

    // pwm: period of 255 counts, so full duty never drops low
    n.pdiv = q.pdiv + 8'h01;
    if (q.pdiv == 8'(PWM_DIV - 1))
    begin
      n.pdiv = '0;
      n.pwmc = (q.pwmc == PWM_TOP) ? 8'h00 : q.pwmc + 8'h01;
    end
    for (int i = 0; i < NCH; i++)
    begin
      if (q.chcfg[F_PIN + i])
        n.drv_oe_n[i] = 1'b1;
      else
        n.drv_oe_n[i] = (q.pwmc < q.duty[i]);
    end

    // start-up duty from the select pins, taken once
    case (q.st)
      S_INIT:
      begin
        for (int i = 0; i < NCH; i++)
        begin
          n.cht[i][7:0] = INIT_DUTY[{I_INITIAL_DUTY_SELECT_HI,
                                     I_INITIAL_DUTY_SELECT_LO}];
          n.duty[i] = n.cht[i][7:0];
          n.rpmd[i] = n.cht[i][7:0];
        end
        n.st = S_RUN;
      end
      S_RUN:
      begin
        n.st = S_RUN;
      end
      default:
      begin
        n.st = S_INIT;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= S_INIT;
      q.gcfg <= GCFG_RST;
      q.chcfg <= CHCFG_RST;
      q.cht <= {NCH{CHT_RST}};
      q.imask <= IMASK_RST;
      q.drv_oe_n <= '1;
      q.fail_oe_n <= 1'b1;
    end
    else if (I_CE)
      q <= n;
  end

  assign O_PRDATA = q.prdata;
  assign O_PREADY = q.pready;
  assign O_PSLVERR = q.pslverr;
  assign O_FAN_DRIVE_OUTPUT_O = '0;
  assign O_FAN_DRIVE_OUTPUT_OE_N = q.drv_oe_n;
  assign O_FAN_FAIL_O = 1'b0;
  assign O_FAN_FAIL_OE_N = q.fail_oe_n;
  assign O_CRYSTAL_PIN_OUT = xout;
  assign O_OSC_CLOCK_OUTPUT = osc_clk;
  assign O_IRQ = q.irq;
endmodule

// File: tb/fdpc_top_assertions.sv
// port-level checker for the fan drive pin control
// assumes it is bound into fdpc_top and sees only that module's ports
`timescale 1ns/1ps
module fdpc_top_assertions
  import fdpc_pkg::*;
(
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic [NCH-1:0] O_FAN_DRIVE_OUTPUT_O,
  input wire logic O_FAN_FAIL_O,
  input wire logic O_OSC_CLOCK_OUTPUT
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RSTN);
  AST_FAN_LOW_ONLY: assert property (O_FAN_DRIVE_OUTPUT_O == '0)
    else $error("fan pin driven high");
  AST_ALARM_LOW_ONLY: assert property (O_FAN_FAIL_O == 1'b0)
    else $error("alarm pin driven high");
  AST_OSC_RUNS: assert property (1'b1 |-> ##[1:400] $changed(O_OSC_CLOCK_OUTPUT))
    else $error("clock output stopped");
  AST_READY_ONE_WAIT: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
    else $error("ready not one cycle after access");
  AST_READY_PULSE: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held longer than one cycle");
  AST_READY_CAUSE: assert property (O_PREADY |-> $past(I_PSEL) && $past(I_PENABLE))
    else $error("ready without access phase");
  AST_ERR_WITH_READY: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  AST_ERR_READ_ZERO: assert property (O_PSLVERR && !I_PWRITE |-> O_PRDATA == '0)
    else $error("refused read returned data");
endmodule
bind fdpc_top fdpc_top_assertions u_chk (
  .I_REF_CLK, .I_RSTN, .I_PSEL, .I_PENABLE, .I_PWRITE, .O_PRDATA,
  .O_PREADY, .O_PSLVERR, .O_FAN_DRIVE_OUTPUT_O, .O_FAN_FAIL_O,
  .O_OSC_CLOCK_OUTPUT
);

// File: tb/fdpc_fan_model.sv
// bank of six fans: tach pulses, stalled-rotor level, open-drain pins
// assumes i_oe_n low means the controller pulls the fan pin low
`timescale 1ns/1ps
module fdpc_fan_model
  import fdpc_pkg::*;
#(
  parameter int HALF = 2442
)
(
  input wire logic i_clk,
  input wire logic [NCH-1:0] i_oe_n,
  input wire logic [NCH-1:0] i_lock,
  output logic [NCH-1:0] o_spd,
  output logic [NCH-1:0] o_pin
);
  int cnt = 0;
  logic tach = 1'b0;
  always @(posedge i_clk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      tach <= ~tach;
  end
  // a stalled rotor parks its tach line high
  assign o_spd = i_lock | {NCH{tach}};
  // pull-up wins only while neither side pulls the line low
  assign o_pin = i_oe_n & {NCH{tach}};
endmodule

// File: tb/tb_fdpc_top.sv
// self-checking bench for the fan drive pin control
// assumes fdpc_top, the fan model and the bound checker are compiled
`timescale 1ns/1ps
module tb_fdpc_top
  import fdpc_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic ovr_n = 1'b1;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b0;
  logic xtal = 1'b0;
  logic [NCH-1:0] lock = '0;
  logic [31:0] prdata;
  logic pready, pslverr, fail_oe_n, xout, osc, irq;
  logic [NCH-1:0] oe_n, spd, pin;
  int miscompares = 0;
  int tests_run = 0;
  initial
    forever #50 clk = ~clk;
  // crystal stand-in, slow enough to see every level settle
  initial
    forever
    begin
      repeat (150) @(posedge clk);
      xtal <= ~xtal;
    end
  fdpc_top #(.PWM_DIV(1)) uut (
    .I_REF_CLK(clk), .I_RSTN(rstn), .I_CE(1'b1), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_SPEED_PULSE_INPUT(spd), .I_FAN_DRIVE_OUTPUT_I(pin),
    .O_FAN_DRIVE_OUTPUT_O(), .O_FAN_DRIVE_OUTPUT_OE_N(oe_n),
    .I_FULL_SPEED_N(ovr_n), .O_FAN_FAIL_O(), .O_FAN_FAIL_OE_N(fail_oe_n),
    .I_INITIAL_DUTY_SELECT_LO(sel_lo), .I_INITIAL_DUTY_SELECT_HI(sel_hi),
    .I_CRYSTAL_PIN_IN(xtal), .O_CRYSTAL_PIN_OUT(xout),
    .O_OSC_CLOCK_OUTPUT(osc), .O_IRQ(irq)
  );
  fdpc_fan_model fans (.i_clk(clk), .i_oe_n(oe_n), .i_lock(lock),
    .o_spd(spd), .o_pin(pin));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic timeout();
    miscompares++;
    $display("unexpected t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    finish_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo,
    input logic [31:0] hi);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      miscompares++;
      $display("unexpected t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
      timeout();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic do_reset(input logic [1:0] s);
    rstn <= 1'b0;
    sel_lo <= s[0];
    sel_hi <= s[1];
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  // one pwm period is 255 cycles, so the high count equals the duty
  task automatic high_count(input int ch, output int n);
    n = 0;
    repeat (255)
    begin
      @(negedge clk);
      if (oe_n[ch] === 1'b1)
        n++;
    end
    // hand back on a rising edge so the next stimulus lands there
    @(posedge clk);
  endtask
  task automatic wait_osc(input logic v, output int n);
    for (n = 0; n < 400 && osc !== v; n++)
      @(posedge clk);
    if (n == 400)
      timeout();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_init();
    int s, n;
    for (s = 0; s < 4; s++)
    begin
      do_reset(2'(s));
      high_count(s, n);
      chk(32'(n), 32'(INIT_DUTY[s]));
      chk(32'(fail_oe_n), 32'h1);
    end
    $display("test initial duty done");
  endtask
  task automatic t_osc();
    int a, b;
    wait_osc(1'b0, a);
    wait_osc(1'b1, a);
    wait_osc(1'b0, a);
    wait_osc(1'b1, b);
    chk_rng(32'(a + b), 32'd304, 32'd307);
    $display("test internal clock done");
  endtask
  task automatic t_pwm();
    logic [31:0] q;
    logic e;
    int n;
    apb(1'b0, 8'hFC, '0, q, e);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    wr(A_CHT0 + A_STEP, 32'h80);
    repeat (300) @(posedge clk);
    high_count(1, n);
    chk(32'(n), 32'h80);
    wr(A_CHCFG, 32'h2);
    repeat (4) @(posedge clk);
    high_count(1, n);
    chk(32'(n), 32'hFF);
    $display("test pwm drive done");
  endtask
  task automatic t_tach();
    logic [31:0] q;
    logic e;
    int n;
    wr(A_CHT0 + 8'h0C, 32'h80640000);
    // tach period 4884 cycles is four ticks of 8192 Hz
    repeat (14652) @(posedge clk);
    apb(1'b0, A_TCNT0, '0, q, e);
    chk_rng(q, 32'd3, 32'd5);
    apb(1'b0, A_TCNT0 + 8'h1C, '0, q, e);
    chk_rng(q, 32'd3, 32'd5);
    // every measurement is under the target count, so duty drops one step per measurement
    high_count(3, n);
    chk_rng(32'(n), 32'hFA, 32'hFD);
    $display("test tach count done");
  endtask
  task automatic t_xtal();
    int s, n;
    logic v;
    wr(A_GCFG, 32'h1);
    for (s = 0; s < 2; s++)
    begin
      v = xtal;
      for (n = 0; n < 200 && xtal === v; n++)
        @(posedge clk);
      if (n == 200)
        timeout();
      repeat (10) @(posedge clk);
      chk(32'(osc), 32'(xtal));
      chk(32'(xout), 32'(!xtal));
    end
    $display("test crystal source done");
  endtask
  task automatic t_fault();
    logic [31:0] q;
    logic e;
    int n;
    wr(A_IMASK, 32'h1);
    wr(A_CHCFG, 32'h01000042);
    lock <= 6'h01;
    for (n = 0; n < 4000 && fail_oe_n !== 1'b0; n++)
      @(negedge clk);
    if (n == 4000)
      timeout();
    chk(32'(fail_oe_n), 32'h0);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h1);
    apb(1'b0, A_STAT, '0, q, e);
    chk(q, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    ovr_n <= 1'b0;
    wr(A_GCFG, 32'h3);
    repeat (300) @(posedge clk);
    high_count(0, n);
    chk(32'(n), 32'h0);
    high_count(2, n);
    chk(32'(n), 32'hFF);
    wr(A_CHCFG, 32'h01001042);
    repeat (4) @(posedge clk);
    chk(32'(fail_oe_n), 32'h1);
    $display("test fault and override done");
  endtask
  initial
  begin
    t_init();
    t_osc();
    t_pwm();
    t_tach();
    t_xtal();
    t_fault();
    finish_test();
  end
endmodule
